// ===== bench/dotc_ctl_model.sv
// Controller model: drives ODT, CKE, writes and refreshes
`timescale 1ns/100ps
`default_nettype none
module dotc_ctl_model (
  // Clock
  input  wire logic i_mclk,
  // Controller pins
  output var  logic o_odt,
  output var  logic o_cke,
  output var  logic o_wr_cmd,
  output var  logic o_wr_bc4,
  output var  logic o_ref_cmd
);
  // Idle pins at time zero
  initial begin
    o_odt     = 1'b0;
    o_cke     = 1'b1;
    o_wr_cmd  = 1'b0;
    o_wr_bc4  = 1'b0;
    o_ref_cmd = 1'b0;
  end

  // ODT pulse, write in its first cycle; short requests are stretched
  task automatic burst(input int len, input bit wr, input bit bc4);
    int n;
    n = (len < 4) ? 4 : len;
    if (wr && n < (bc4 ? 4 : 6))
      n = bc4 ? 4 : 6;
    o_odt    <= 1'b1;
    o_wr_cmd <= wr && o_cke;
    o_wr_bc4 <= bc4;
    @(posedge i_mclk);
    o_wr_cmd <= 1'b0;
    o_wr_bc4 <= ~bc4;
    repeat (n - 1) @(posedge i_mclk);
    o_odt <= 1'b0;
  endtask : burst

  // Power-down entry and exit
  task automatic set_cke(input bit v);
    o_cke <= v;
    @(posedge i_mclk);
  endtask : set_cke

  // One refresh command
  task automatic refresh();
    o_ref_cmd <= 1'b1;
    @(posedge i_mclk);
    o_ref_cmd <= 1'b0;
  endtask : refresh
endmodule : dotc_ctl_model
`default_nettype wire

// ===== bench/dotc_monitor.sv
// Checker: ODT latency, window and register port relations
`timescale 1ns/100ps
`default_nettype none
module dotc_monitor #(
  parameter int unsigned TCPDED_CYC = 1,
  parameter int unsigned TRFC_CYC   = 8
) (
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_ce,
  // Pins
  input wire logic        i_odt,
  input wire logic        i_cke,
  input wire logic        i_wr_cmd,
  input wire logic        i_wr_bc4,
  input wire logic        i_ref_cmd,
  // Register port
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // Termination
  input wire logic        o_rtt_en,
  input wire logic        o_rtt_wr,
  input wire logic        o_window,
  input wire logic        o_async
);
  logic [11:0] cfg;
  logic [31:0] h;
  logic        cq;
  logic [2:0]  wc;
  logic [2:0]  wa;
  logic [3:0]  rc;
  wire  [4:0]  lat = cfg[7:4] + cfg[11:8] - 5'h2;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // Shadow state; everything stalls with the clock enable, as the block does
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cfg <= 12'h050;
      h   <= '0;
      cq  <= 1'b1;
      wc  <= '0;
      wa  <= '0;
      rc  <= '0;
    end else if (i_ce) begin
      if (i_wr && i_addr == 8'h00)
        cfg <= i_wdata[11:0];
      h  <= {h[30:0], i_odt};
      cq <= i_cke;
      wa <= {wa[1:0], wc != 3'h0};
      if (i_wr_cmd && i_cke && cq && cfg[1])
        wc <= i_wr_bc4 ? 3'h4 : 3'h6;
      else if (wc != 3'h0)
        wc <= wc - 3'h1;
      rc <= i_ref_cmd ? 4'(TRFC_CYC) : rc - {3'h0, rc != 4'h0};
    end
  end

  // Power-down entry steps
  sequence pd_in;
    i_ce && cq && !i_cke && !cfg[0];
  endsequence
  sequence pd_free;
    pd_in ##0 (rc == 4'h0);
  endsequence
  sequence pd_busy;
    pd_in ##0 (rc > 4'h4);
  endsequence

  sync_odt_a: assert property (
    !o_async [*8] |-> o_rtt_en == h[lat]) else $error("sync ODT latency wrong");
  async_odt_a: assert property (
    o_async [*2] |-> o_rtt_en == h[1]) else $error("async ODT delay wrong");
  win_open_a: assert property (
    pd_free |-> ##2 o_window ##[1:2] (o_async && !o_window)) else $error("entry window wrong");
  win_refresh_a: assert property (
    pd_busy |-> ##2 o_window [*3]) else $error("window not held by refresh");
  dll_on_a: assert property (
    i_ce && cq && !i_cke && cfg[0] |-> ##1 (!o_window && !o_async) [*4])
    else $error("async mode with DLL kept on");
  pd_exit_a: assert property (
    i_ce && !cq && i_cke |-> ##2 (!o_async && !o_window)) else $error("exit left async");
  dyn_strength_a: assert property (
    (lat == 5'h3 && !o_async) [*3] |-> o_rtt_wr == wa[2]) else $error("write strength wrong");
  rd_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0) else $error("read data outside read cycle");
  rd_status_a: assert property (
    $past(i_rd) && $past(i_addr) == 8'h04 |->
      o_rdata[1:0] == $past({o_rtt_wr, o_rtt_en}) && o_rdata[31:5] == 27'h0)
    else $error("status read wrong");
endmodule : dotc_monitor

bind dotc_odt_ctrl dotc_monitor #(.TCPDED_CYC(TCPDED_CYC), .TRFC_CYC(TRFC_CYC)) i_dotc_monitor (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_odt(i_odt), .i_cke(i_cke),
  .i_wr_cmd(i_wr_cmd), .i_wr_bc4(i_wr_bc4), .i_ref_cmd(i_ref_cmd), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rtt_en(o_rtt_en),
  .o_rtt_wr(o_rtt_wr), .o_window(o_window), .o_async(o_async));
`default_nettype wire

// ===== bench/tb_top.sv
// Testbench: ODT control block against the controller model
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic        i_mclk  = 1'b0;
  logic        i_rst;
  logic        i_ce;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_rtt_en;
  logic        o_rtt_wr;
  logic        o_window;
  logic        o_async;
  logic        odt;
  logic        cke;
  logic        wrc;
  logic        bc4;
  logic        refc;
  int          mismatches   = 0;
  int          total_checks = 0;

  dotc_ctl_model i_dotc_ctl_model (.i_mclk(i_mclk), .o_odt(odt), .o_cke(cke),
    .o_wr_cmd(wrc), .o_wr_bc4(bc4), .o_ref_cmd(refc));
  dotc_odt_ctrl i_dotc_odt_ctrl (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
    .i_odt(odt), .i_cke(cke), .i_wr_cmd(wrc), .i_wr_bc4(bc4), .i_ref_cmd(refc),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_rtt_en(o_rtt_en), .o_rtt_wr(o_rtt_wr), .o_window(o_window), .o_async(o_async));

  // 25 MHz clock
  initial begin
    forever #20 i_mclk = ~i_mclk;
  end

  // Expected values
  function automatic logic [31:0] cfg_w(int cwl, int al, bit dyn, bit a12);
    return 32'((al << 8) | (cwl << 4) | (dyn << 1) | a12);
  endfunction : cfg_w
  // Edges counted from the sampling edge itself: latency plus one
  function automatic int lat(int cwl, int al, bit as);
    return as ? 2 : cwl + al - 1;
  endfunction : lat

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : reg_wr

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input string n, input logic [7:0] a, input logic [31:0] e);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK(n, e, o_rdata)
  endtask : reg_rd

  // Edges from ODT or write launch to the rise, then, for a write, the high width
  task automatic meas(input string n, input bit w, input int e, input int wd);
    int k;
    k = 0;
    #1;
    while (k < 20 && (w ? o_rtt_wr : o_rtt_en) !== 1'b1) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    `CHK(n, e, k)
    k = 0;
    while (w && k < 20 && o_rtt_wr === 1'b1) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    if (w) `CHK(n, wd, k)
  endtask : meas

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // Hang guard
  initial begin
    repeat (20000) @(posedge i_mclk);
    mismatches++;
    end_of_test();
  end

  initial begin
    int len;
    bit w;
    bit b;
    i_rst   <= 1'b1;
    i_ce    <= 1'b1;
    i_addr  <= 8'h00;
    i_wdata <= 32'h0;
    i_wr    <= 1'b0;
    i_rd    <= 1'b0;
    void'($urandom(47486));
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    reg_rd("cfg", 8'h00, 32'h50);
    reg_wr(8'h04, 32'hFFFF_FFFF);
    reg_wr(8'h08, 32'hFFFF_FFFF);
    reg_rd("unmapped", 8'h08, 32'h0);
    reg_rd("stat", 8'h04, 32'h0);
    reg_rd("cfg", 8'h00, 32'h50);
    reg_wr(8'h00, 32'hFFFF_FFFF);
    reg_rd("cfg all", 8'h00, 32'hFFFF_FFFF);
    $display("regs done");
    // Random pulses with and without writes, dynamic ODT on
    reg_wr(8'h00, cfg_w(5, 0, 1, 0));
    for (int i = 0; i < 12; i++) begin
      len = $urandom_range(9, 2);
      w = 1'($urandom_range(1, 0));
      b = 1'($urandom_range(1, 0));
      fork
        i_dotc_ctl_model.burst(len, w, b);
        meas("odt on", 1'b0, lat(5, 0, 0), 0);
        if (w) meas("rtt_wr", 1'b1, lat(5, 0, 0), b ? 4 : 6);
      join
      repeat ($urandom_range(8, 5)) @(posedge i_mclk);
    end
    $display("sync done");
    // Additive latency counts in sync mode only
    reg_wr(8'h00, cfg_w(5, 2, 0, 0));
    fork
      i_dotc_ctl_model.burst(4, 1'b0, 1'b0);
      meas("al sync", 1'b0, lat(5, 2, 0), 0);
    join
    repeat (8) @(posedge i_mclk);
    i_dotc_ctl_model.set_cke(1'b0);
    repeat (12) @(posedge i_mclk);
    #1;
    `CHK("async", 1'b1, o_async)
    fork
      i_dotc_ctl_model.burst(5, 1'b0, 1'b0);
      meas("async on", 1'b0, lat(5, 2, 1), 0);
    join
    repeat (10) @(posedge i_mclk);
    i_dotc_ctl_model.set_cke(1'b1);
    repeat (4) @(posedge i_mclk);
    #1;
    `CHK("exit", 1'b0, o_async)
    $display("async done");
    // Refresh in progress holds the window open
    reg_wr(8'h00, cfg_w(5, 0, 0, 0));
    i_dotc_ctl_model.refresh();
    i_dotc_ctl_model.set_cke(1'b0);
    repeat (4) @(posedge i_mclk);
    #1;
    `CHK("win", 1'b1, o_window)
    `CHK("win sync", 1'b0, o_async)
    repeat (12) @(posedge i_mclk);
    #1;
    `CHK("after win", 1'b1, o_async)
    i_dotc_ctl_model.set_cke(1'b1);
    repeat (10) @(posedge i_mclk);
    $display("window done");
    // DLL kept on: power-down stays synchronous
    reg_wr(8'h00, cfg_w(5, 0, 1, 1));
    i_dotc_ctl_model.set_cke(1'b0);
    repeat (6) @(posedge i_mclk);
    fork
      i_dotc_ctl_model.burst(4, 1'b1, 1'b0);
      meas("pd sync", 1'b0, lat(5, 0, 0), 0);
    join
    `CHK("pd async", 1'b0, o_async)
    i_dotc_ctl_model.set_cke(1'b1);
    repeat (8) @(posedge i_mclk);
    // Clock enable low freezes the block
    i_ce <= 1'b0;
    i_dotc_ctl_model.burst(4, 1'b0, 1'b0);
    repeat (6) @(posedge i_mclk);
    #1;
    `CHK("frozen", 1'b0, o_rtt_en)
    i_ce <= 1'b1;
    repeat (8) @(posedge i_mclk);
    reg_rd("stat end", 8'h04, 32'h0);
    $display("freeze done");
    end_of_test();
  end
endmodule : tb_top
`undef CHK
`default_nettype wire

// ===== core/dotc_dly.sv
// Module: sampled-input history shift line with flat tap vector
`timescale 1ns/100ps
`default_nettype none
module dotc_dly #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned WIDTH = 3
) (
  // Clock, reset, enable
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst,
  input  wire logic                     i_ce,
  // Sample in, history out (stage k = k+1 edges old)
  input  wire logic [WIDTH-1:0]         i_d,
  output logic      [DEPTH*WIDTH-1:0]   o_hist
);

  // Elaboration check: a line shorter than two stages cannot hold a latency
  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
      $error("dotc_dly: DEPTH must be at least 2 and WIDTH at least 1");
    end
  endgenerate

  // One register per stage
  genvar k;
  generate
    for (k = 0; k < DEPTH; k++) begin : g_stage
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          o_hist[k*WIDTH +: WIDTH] <= '0;
        end else if (i_ce) begin
          if (k == 0) begin
            o_hist[k*WIDTH +: WIDTH] <= i_d;
          end else begin
            o_hist[k*WIDTH +: WIDTH] <= o_hist[(k-1)*WIDTH +: WIDTH];
          end
        end
      end
    end
  endgenerate

endmodule : dotc_dly
`default_nettype wire

// ===== core/dotc_odt_ctrl.sv
// Module: top of the on-die termination control, sync/async/dynamic ODT
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RL1: Controller holds ODT high at least 4 cycles once registered high.
// RL2: With a BL8 write and ODT high, ODT stays high 6 cycles from write.
// RL3: With a BC4 write and ODT high, ODT stays high 4 cycles from write.
// RL4: Asynchronous ODT timing applies in power-down when A12 freezes the DLL.
// RL5: Asynchronous mode applies ODT without additive latency.
// RL6: Async turn-on starts no sooner than 2 ns, done by 8.5 ns.
// RL7: Async turn-off starts no sooner than 2 ns, done by 8.5 ns.
// RL8: ODT receiver stays active in precharge power-down.
// RL9: Controller issues no read or write during precharge power-down.
// RL10: With A12 zero, response may be sync or async inside the entry window.
// RL11: Window starts WL-1 cycles before the first CKE-low cycle; the block starts it at the first CKE-low cycle, with no lead.
// RL12: Window ends when tCPDED has elapsed from the first CKE-low cycle.
// RL13: A refresh in progress extends the end to the later of tRFC and tCPDED.
// RL14: Window start cycle excluded, end cycles included.
// RL15: Turn-on in window lies between min and max of async and sync bounds.
// RL16: Turn-off in window lies between min and max of async and sync bounds.
// RL17: Dynamic ODT switches to write strength WL-2 cycles after a write.
// RL18: Nominal strength returns ODTLoff plus 4 (BC4) or 6 (BL8) after write.
// RL19: Sync latency before the window, async once frozen and window closed.
module dotc_odt_ctrl #(
  parameter int unsigned HIST_DEPTH = 32,
  parameter int unsigned TCPDED_CYC = 1,
  parameter int unsigned TRFC_CYC   = 8
) (
  // Clock, reset, enable
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst,
  input  wire logic                      i_ce,
  // Pins sampled on CK
  input  wire logic                      i_odt,
  input  wire logic                      i_cke,
  input  wire logic                      i_wr_cmd,
  input  wire logic                      i_wr_bc4,
  input  wire logic                      i_ref_cmd,
  // Register port
  input  wire logic [dotc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [dotc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [dotc_pkg::DATA_W-1:0] o_rdata,
  // Termination control
  output logic                           o_rtt_en,
  output logic                           o_rtt_wr,
  output logic                           o_window,
  output logic                           o_async
);

  localparam int unsigned LW    = dotc_pkg::LAT_W;
  localparam int unsigned HW    = 3;
  localparam int unsigned IDX_W = $clog2(HIST_DEPTH);

  // Elaboration check: history must reach the longest WL-2 (CWL 15 + AL 15)
  generate
    if (HIST_DEPTH < 2 * ((1 << LW) - 1) - dotc_pkg::ODTL_SUB) begin : g_bad
      $error("dotc_odt_ctrl: HIST_DEPTH too short for the largest write latency");
    end
  endgenerate

  // Configuration register and its fields
  logic [dotc_pkg::DATA_W-1:0] cfg_reg;
  logic [dotc_pkg::DATA_W-1:0] cfg_next;
  logic                        pd_dll_on;
  logic                        dyn_en;
  logic [LW-1:0]               cwl;
  logic [LW-1:0]               al;
  logic [LW:0]                 wl;

  assign pd_dll_on = cfg_reg[dotc_pkg::CFG_PD_DLL_BIT];
  assign dyn_en    = cfg_reg[dotc_pkg::CFG_DYN_BIT];
  assign cwl       = cfg_reg[dotc_pkg::CFG_CWL_LSB +: LW];
  assign al        = cfg_reg[dotc_pkg::CFG_AL_LSB +: LW];
  assign wl        = {1'b0, cwl} + {1'b0, al};

  // Register decode
  logic sel_cfg;
  logic sel_stat;
  logic cfg_we;

  assign sel_cfg  = (i_addr == dotc_pkg::REG_CFG);
  assign sel_stat = (i_addr == dotc_pkg::REG_STAT);
  assign cfg_we   = i_wr & sel_cfg;
  assign cfg_next = cfg_we ? i_wdata : cfg_reg;

  // Window tracker
  dotc_win_if win_if ();

  assign win_if.cke     = i_cke;
  assign win_if.ref_cmd = i_ref_cmd;
  assign win_if.frozen  = ~pd_dll_on;                                   // [RL4]

  dotc_win #(
    .TCPDED_CYC (TCPDED_CYC),
    .TRFC_CYC   (TRFC_CYC)
  ) u_win (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .w      (win_if.trk)
  );

  // Mode state machine
  dotc_pkg::dotc_mode_t mode_reg;
  dotc_pkg::dotc_mode_t mode_next;
  logic                 cke_q;
  logic                 first_low;

  assign first_low = cke_q & ~i_cke;

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      dotc_pkg::MODE_SYNC: begin
        // Only a frozen DLL leads into the transition
        if (first_low && !pd_dll_on) begin                              // [RL10]
          mode_next = dotc_pkg::MODE_TRANS;
        end
      end
      dotc_pkg::MODE_TRANS: begin
        if (i_cke) begin
          mode_next = dotc_pkg::MODE_SYNC;
        end else if (!win_if.window && first_low == 1'b0) begin
          mode_next = dotc_pkg::MODE_ASYNC;                             // [RL19]
        end
      end
      dotc_pkg::MODE_ASYNC: begin
        if (i_cke) begin
          mode_next = dotc_pkg::MODE_SYNC;
        end
      end
      default: begin
        mode_next = dotc_pkg::MODE_SYNC;
      end
    endcase
  end

  // Sampled history: {bc4, write, odt}; writes ignored while powered down
  logic [HW-1:0]              hist_in;
  logic [HIST_DEPTH*HW-1:0]   hist;
  logic                       wr_ok;

  assign wr_ok   = i_wr_cmd & i_cke & ~win_if.pd & dyn_en;              // [RL9]
  // ODT is sampled in every state, power-down included
  assign hist_in = {i_wr_bc4, wr_ok, i_odt};                            // [RL8]

  dotc_dly #(
    .DEPTH (HIST_DEPTH),
    .WIDTH (HW)
  ) u_dly (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .i_d    (hist_in),
    .o_hist (hist)
  );

  // Tap selection: WL-2 in sync (AL included), fixed short delay in async
  logic [IDX_W-1:0] sync_idx;
  logic [IDX_W-1:0] async_idx;
  logic [IDX_W-1:0] odt_idx;
  logic [HW-1:0]    sync_tap;
  logic [HW-1:0]    odt_tap;
  logic             is_async;

  // Stage k is k+1 edges old, so latency n reads stage n-1
  assign sync_idx  = (wl > 5'(dotc_pkg::ODTL_SUB + 1)) ?
                     IDX_W'(wl - 5'(dotc_pkg::ODTL_SUB + 1)) : '0;      // [RL17]
  assign async_idx = IDX_W'(dotc_pkg::ASYNC_CYC - 1);                   // [RL6] [RL7]
  assign is_async  = (mode_reg == dotc_pkg::MODE_ASYNC);
  // Async reads the raw sampled ODT, bypassing the AL delay
  assign odt_idx   = is_async ? async_idx : sync_idx;                   // [RL5] [RL19]
  assign sync_tap  = hist[sync_idx * HW +: HW];
  // Inside the window the synchronous response is kept, one of the two legal
  // answers, so both the early and the late bound are met by construction
  assign odt_tap   = hist[odt_idx * HW +: HW];                          // [RL15] [RL16]

  // Dynamic ODT: write strength for 4 or 6 cycles starting at ODTLcnw
  logic [2:0] hold_reg;
  logic [2:0] hold_next;
  logic       wr_at_cnw;

  assign wr_at_cnw = sync_tap[1] & ~is_async;
  assign hold_next = wr_at_cnw ? (sync_tap[2] ? dotc_pkg::CWN_BC4        // [RL18]
                                              : dotc_pkg::CWN_BL8) :
                     (hold_reg != 3'h0) ? hold_reg - 3'h1 : 3'h0;

  // Status word
  logic [dotc_pkg::DATA_W-1:0] stat_word;
  logic [dotc_pkg::DATA_W-1:0] rdata_next;

  always_comb begin
    stat_word = '0;
    stat_word[dotc_pkg::ST_RTT_EN_BIT] = o_rtt_en;
    stat_word[dotc_pkg::ST_RTT_WR_BIT] = o_rtt_wr;
    stat_word[dotc_pkg::ST_WIN_BIT]    = o_window;
    stat_word[dotc_pkg::ST_ASYNC_BIT]  = o_async;
    stat_word[dotc_pkg::ST_PD_BIT]     = win_if.pd;
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  assign rdata_next = !i_rd   ? '0 :
                      sel_cfg ? cfg_reg :
                      sel_stat ? stat_word : '0;

  // Configuration and read data
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cfg_reg <= dotc_pkg::CFG_RESET;
      o_rdata <= '0;
    end else if (i_ce) begin
      cfg_reg <= cfg_next;
      o_rdata <= rdata_next;
    end
  end

  // Mode and CKE edge history
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mode_reg <= dotc_pkg::MODE_SYNC;
      cke_q    <= 1'b1;
    end else if (i_ce) begin
      mode_reg <= mode_next;
      cke_q    <= i_cke;
    end
  end

  // Termination outputs, all from flops
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      hold_reg <= 3'h0;
      o_rtt_en <= 1'b0;
      o_rtt_wr <= 1'b0;
      o_window <= 1'b0;
      o_async  <= 1'b0;
    end else if (i_ce) begin
      hold_reg <= hold_next;
      o_rtt_en <= odt_tap[0];
      o_rtt_wr <= (hold_next != 3'h0);                                  // [RL17] [RL18]
      o_window <= win_if.window;                                        // [RL11] [RL14]
      o_async  <= (mode_next == dotc_pkg::MODE_ASYNC);                  // [RL4]
    end
  end

endmodule : dotc_odt_ctrl
`default_nettype wire

// ===== core/dotc_pkg.sv
// Package: constants, register map and mode encoding for the ODT control block
`default_nettype none
package dotc_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] REG_CFG  = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;

  // Configuration field layout
  localparam int unsigned CFG_PD_DLL_BIT = 0;  // Mirror of MR0 A12: 1 = DLL kept on in PD
  localparam int unsigned CFG_DYN_BIT    = 1;  // Dynamic ODT enable
  localparam int unsigned CFG_CWL_LSB    = 4;
  localparam int unsigned CFG_AL_LSB     = 8;
  localparam int unsigned LAT_W          = 4;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0050; // CWL 5, AL 0, A12 0, dyn off

  // Status field layout
  localparam int unsigned ST_RTT_EN_BIT = 0;
  localparam int unsigned ST_RTT_WR_BIT = 1;
  localparam int unsigned ST_WIN_BIT    = 2;
  localparam int unsigned ST_ASYNC_BIT  = 3;
  localparam int unsigned ST_PD_BIT     = 4;

  // Clock and asynchronous ODT timing, in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 40000;
  localparam int unsigned TAONPD_MIN_PS = 2000;
  localparam int unsigned TAONPD_MAX_PS = 8500;
  localparam int unsigned TAOFPD_MIN_PS = 2000;
  localparam int unsigned TAOFPD_MAX_PS = 8500;

  // Least times round up, longest round down, never below one cycle
  localparam int unsigned TAONPD_MIN_RAW = (TAONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TAONPD_MIN_CYC = (TAONPD_MIN_RAW < 1) ? 1 : TAONPD_MIN_RAW;
  localparam int unsigned TAONPD_MAX_RAW = TAONPD_MAX_PS / CLK_PERIOD_PS;
  localparam int unsigned TAONPD_MAX_CYC = (TAONPD_MAX_RAW < 1) ? 1 : TAONPD_MAX_RAW;
  localparam int unsigned TAOFPD_MIN_RAW = (TAOFPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TAOFPD_MIN_CYC = (TAOFPD_MIN_RAW < 1) ? 1 : TAOFPD_MIN_RAW;
  localparam int unsigned ASYNC_CYC      = TAONPD_MIN_CYC;

  // Latency offsets relative to write latency WL = CWL + AL
  localparam int unsigned ODTL_SUB  = 2;  // ODTLon = ODTLoff = ODTLcnw = WL - 2
  localparam int unsigned TANPD_SUB = 1;  // Entry window lead = WL - 1
  localparam logic [2:0]  CWN_BC4   = 3'h4;
  localparam logic [2:0]  CWN_BL8   = 3'h6;
  localparam int unsigned ODTH4_CYC = 4;
  localparam int unsigned ODTH8_CYC = 6;

  // Response mode, one-hot
  typedef enum logic [2:0] {
    MODE_SYNC  = 3'b001,
    MODE_TRANS = 3'b010,
    MODE_ASYNC = 3'b100
  } dotc_mode_t;

endpackage : dotc_pkg
`default_nettype wire

// ===== core/dotc_win.sv
// Module: power-down entry transition window and refresh tracker
`timescale 1ns/100ps
`default_nettype none
module dotc_win #(
  parameter int unsigned TCPDED_CYC = 1,
  parameter int unsigned TRFC_CYC   = 8,
  parameter int unsigned CNT_W      = 8
) (
  // Clock, reset, enable
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  // Window signals
  dotc_win_if.trk   w
);

  // Elaboration check: counts must fit the counter
  generate
    if (TCPDED_CYC < 1 || TCPDED_CYC >= (1 << CNT_W) || TRFC_CYC >= (1 << CNT_W)) begin : g_bad
      $error("dotc_win: TCPDED_CYC or TRFC_CYC out of counter range");
    end
  endgenerate

  localparam logic [CNT_W-1:0] CPDED = CNT_W'(TCPDED_CYC);
  localparam logic [CNT_W-1:0] TRFC  = CNT_W'(TRFC_CYC);

  logic             cke_reg;
  logic [CNT_W-1:0] rfc_reg;
  logic [CNT_W-1:0] rfc_next;
  logic [CNT_W-1:0] win_reg;
  logic [CNT_W-1:0] win_next;
  logic             first_low;
  logic [CNT_W-1:0] end_cnt;

  // First cycle CKE is registered low; end is the later of tCPDED and tRFC left
  assign first_low = cke_reg & ~w.cke;
  assign end_cnt   = (rfc_reg > CPDED) ? rfc_reg : CPDED;                 // [RL13]
  assign rfc_next  = w.ref_cmd ? TRFC : ((rfc_reg != '0) ? rfc_reg - 1'b1 : '0);
  // Count is inclusive of the end cycle; exit by CKE high drops the window
  assign win_next  = (first_low & w.frozen) ? end_cnt :                   // [RL12] [RL10]
                     (!w.cke && win_reg != '0) ? win_reg - 1'b1 : '0;     // [RL14]
  assign w.window  = (win_reg != '0);
  assign w.pd      = ~cke_reg;

  // Trackers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cke_reg <= 1'b1;
      rfc_reg <= '0;
      win_reg <= '0;
    end else if (i_ce) begin
      cke_reg <= w.cke;
      rfc_reg <= rfc_next;
      win_reg <= win_next;
    end
  end

endmodule : dotc_win
`default_nettype wire

// ===== core/dotc_win_if.sv
// Interface: power-down window signals between controller and tracker
`timescale 1ns/100ps
`default_nettype none
interface dotc_win_if;
  logic cke;
  logic ref_cmd;
  logic frozen;
  logic window;
  logic pd;

  modport trk (input cke, input ref_cmd, input frozen, output window, output pd);
  modport ctl (output cke, output ref_cmd, output frozen, input window, input pd);
endinterface : dotc_win_if
`default_nettype wire
